// [core/lts_cfg.svh]
`ifndef LTS_CFG_SVH
`define LTS_CFG_SVH
`define LTS_ADDR_LOW_B0 8'h8a
`define LTS_ADDR_LOW_B1 8'h8b
`define LTS_ADDR_LOW_B2 8'h8c
`define LTS_ADDR_HIGH_B0 8'h8d
`define LTS_ADDR_HIGH_B1 8'h8e
`define LTS_ADDR_HIGH_B2 8'h8f
`define LTS_ADDR_PKG_FAB 8'h90
`define LTS_ADDR_DIE_VER 8'h91
`define LTS_ADDR_PART 8'h92
`define LTS_ADDR_STATUS 8'h93
`define LTS_BIT_SAT 7
`define LTS_BIT_LIGHT 3
`define LTS_BIT_FIFO 2
`define LTS_BIT_SYS 0
`define LTS_LIMIT_RESET 24'h000000
`define LTS_STATUS_RESET 8'h00
`endif

// [core/lts_pkg.sv]
package lts_pkg;
  typedef logic [23:0] lts_limit_type;
  typedef logic [7:0] lts_byte_type;
endpackage : lts_pkg

// [core/lts_persist.sv]
// Counts consecutive samples meeting a condition; fires when count exceeds target
module lts_persist
  import lts_pkg::*;
#(
  parameter int CW = 4
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Sample stream
  input wire logic sample_valid,
  input wire logic cond,
  input wire logic [CW-1:0] target,
  // Result
  output logic hit
);
  logic [CW-1:0] cnt_q;
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (sample_valid)
    begin
      if (!cond)
        cnt_q <= '0;
      else if (cnt_q != '1)
        cnt_q <= cnt_q + 1'b1;
    end
  end
  // The current sample completes a run of target + 1; a target of zero fires on every sample meeting the condition
  assign hit = sample_valid && cond && cnt_q >= target;
endmodule : lts_persist

// [core/lts_irq_status.sv]
`include "lts_cfg.svh"
module lts_irq_status
  import lts_pkg::*;
#(
  parameter int NMOD = 3,
  parameter int PW = 4,
  parameter int FW = 8,
  // Identification values are arbitrary
  parameter logic [3:0] PKG_FAB_CODE = 4'h3,
  parameter logic [7:0] DIE_VERSION_CODE = 8'h42,
  parameter logic [7:0] PART_CODE = 8'h7e
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Configuration
  input wire logic light_irq_enable,
  input wire logic system_irq_enable,
  input wire logic [PW-1:0] light_persistence_count,
  input wire logic [1:0] limit_source_select,
  input wire logic [FW-1:0] fifo_fill_threshold,
  // Events and data
  input wire logic [NMOD*24-1:0] mod_data,
  input wire logic mod_data_valid,
  input wire logic saturation_event,
  input wire logic [FW-1:0] fifo_fill_level,
  input wire logic system_event,
  // Outputs
  output logic low_crossing_flag,
  output logic high_crossing_flag,
  output logic irq_n
);
  lts_limit_type low_q, high_q, sel_data;
  logic sat_q, light_q, fifo_q, sys_q, fifo_ack_q;
  logic low_hit, high_hit, wr_status, fifo_cond;
  logic sat_clr, light_clr, fifo_clr, sys_clr;
  logic [PW:0] low_run_q, high_run_q;
  lts_byte_type rd_d;

  // Byte-wide limit registers, written independently with no shadowing
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      low_q <= `LTS_LIMIT_RESET;
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `LTS_ADDR_LOW_B0: low_q[7:0] <= reg_wdata;
        `LTS_ADDR_LOW_B1: low_q[15:8] <= reg_wdata;
        `LTS_ADDR_LOW_B2: low_q[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      high_q <= `LTS_LIMIT_RESET;
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `LTS_ADDR_HIGH_B0: high_q[7:0] <= reg_wdata;
        `LTS_ADDR_HIGH_B1: high_q[15:8] <= reg_wdata;
        `LTS_ADDR_HIGH_B2: high_q[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Out-of-range select falls back to modulator 0
  always_comb
  begin
    sel_data = mod_data[23:0];
    for (int i = 0; i < NMOD; i++)
      if (int'(limit_source_select) == i)
        sel_data = mod_data[i*24 +: 24];
  end

  lts_persist #(.CW(PW)) u_low
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sample_valid(mod_data_valid),
    .cond(sel_data < low_q),
    .target(light_persistence_count),
    .hit(low_hit)
  );

  lts_persist #(.CW(PW)) u_high
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sample_valid(mod_data_valid),
    .cond(sel_data > high_q),
    .target(light_persistence_count),
    .hit(high_hit)
  );

  assign wr_status = reg_wr && reg_addr == `LTS_ADDR_STATUS;
  assign fifo_cond = fifo_fill_level >= fifo_fill_threshold;
  assign sat_clr = wr_status && reg_wdata[`LTS_BIT_SAT];
  assign light_clr = wr_status && reg_wdata[`LTS_BIT_LIGHT];
  assign fifo_clr = wr_status && reg_wdata[`LTS_BIT_FIFO];
  assign sys_clr = wr_status && reg_wdata[`LTS_BIT_SYS];

  // Crossing flags clear with the light flag; set wins over clear so no event is lost
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      light_q <= 1'b0;
    else if (light_irq_enable && (low_hit || high_hit))
      light_q <= 1'b1;
    else if (light_clr)
      light_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      low_crossing_flag <= 1'b0;
    else if (light_irq_enable && low_hit)
      low_crossing_flag <= 1'b1;
    else if (light_clr)
      low_crossing_flag <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      high_crossing_flag <= 1'b0;
    else if (light_irq_enable && high_hit)
      high_crossing_flag <= 1'b1;
    else if (light_clr)
      high_crossing_flag <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      sat_q <= 1'b0;
    else if (saturation_event)
      sat_q <= 1'b1;
    else if (sat_clr)
      sat_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      sys_q <= 1'b0;
    else if (system_irq_enable && system_event)
      sys_q <= 1'b1;
    else if (sys_clr)
      sys_q <= 1'b0;
  end

  // FIFO flag is a level; a clear hides it for one cycle only
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      fifo_q <= 1'b0;
    else
      fifo_q <= fifo_cond && !fifo_clr;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      fifo_ack_q <= 1'b0;
    else
      fifo_ack_q <= fifo_clr;
  end

  // Shadow run counters check the persistence filter independently of its module
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      low_run_q <= '0;
    else if (mod_data_valid)
    begin
      if (sel_data >= low_q)
        low_run_q <= '0;
      else if (low_run_q != '1)
        low_run_q <= low_run_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      high_run_q <= '0;
    else if (mod_data_valid)
    begin
      if (sel_data <= high_q)
        high_run_q <= '0;
      else if (high_run_q != '1)
        high_run_q <= high_run_q + 1'b1;
    end
  end

  always_comb
  begin
    unique case (reg_addr)
      `LTS_ADDR_LOW_B0: rd_d = low_q[7:0];
      `LTS_ADDR_LOW_B1: rd_d = low_q[15:8];
      `LTS_ADDR_LOW_B2: rd_d = low_q[23:16];
      `LTS_ADDR_HIGH_B0: rd_d = high_q[7:0];
      `LTS_ADDR_HIGH_B1: rd_d = high_q[15:8];
      `LTS_ADDR_HIGH_B2: rd_d = high_q[23:16];
      `LTS_ADDR_PKG_FAB: rd_d = {4'h0, PKG_FAB_CODE};
      `LTS_ADDR_DIE_VER: rd_d = DIE_VERSION_CODE;
      `LTS_ADDR_PART: rd_d = PART_CODE;
      `LTS_ADDR_STATUS: rd_d = {sat_q, 3'h0, light_q, fifo_q, 1'b0, sys_q};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_d;
  end

  assign irq_n = !(sat_q || light_q || fifo_q || sys_q);

  sequence s_light_ack;
    wr_status && reg_wdata[`LTS_BIT_LIGHT] && !low_hit && !high_hit;
  endsequence
  sequence s_fifo_steady;
    fifo_cond && !wr_status ##1 fifo_cond;
  endsequence
  sequence s_fifo_ack;
    fifo_clr && fifo_cond ##1 fifo_cond && !wr_status;
  endsequence
  a_sat_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    saturation_event |=> sat_q && !irq_n)
    else $error("saturation flag missed");
  a_sat_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_status && reg_wdata[7] && !saturation_event |=> !sat_q)
    else $error("saturation clear failed");
  a_light_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    !light_q && !light_irq_enable |=> !light_q)
    else $error("light set while off");
  a_light_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_light_ack |=> !light_q && !low_crossing_flag)
    else $error("light clear failed");
  a_low_cross: assert property (@(posedge core_clk) disable iff (!reset_n)
    light_irq_enable && low_hit |=> low_crossing_flag && light_q)
    else $error("low crossing missed");
  a_high_cross: assert property (@(posedge core_clk) disable iff (!reset_n)
    light_irq_enable && high_hit |=> high_crossing_flag && light_q)
    else $error("high crossing missed");
  a_fifo_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_fifo_steady |-> fifo_q)
    else $error("fifo flag wrong");
  a_fifo_reassert: assert property (@(posedge core_clk) disable iff (!reset_n)
    fifo_ack_q && fifo_cond && !wr_status |=> fifo_q)
    else $error("fifo not reasserted");
  a_sys_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    system_irq_enable && system_event |=> sys_q)
    else $error("system flag missed");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd && reg_addr == `LTS_ADDR_STATUS |=> reg_rdata[6:4] == 3'h0 && !reg_rdata[1])
    else $error("reserved bits nonzero");
  a_limit_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_wr && reg_addr == `LTS_ADDR_LOW_B2 |=> low_q[23:16] == $past(reg_wdata))
    else $error("limit write lost");
  a_sys_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    !sys_q && !system_irq_enable |=> !sys_q)
    else $error("system flag set while off");
  a_sys_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    sys_clr && !(system_irq_enable && system_event) |=> !sys_q)
    else $error("system clear failed");
  a_high_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_light_ack |=> !high_crossing_flag)
    else $error("high crossing clear failed");
  a_fifo_hide: assert property (@(posedge core_clk) disable iff (!reset_n)
    fifo_clr |=> !fifo_q)
    else $error("fifo clear ignored");
  a_fifo_back: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_fifo_ack |=> fifo_q)
    else $error("fifo flag not back after clear");
  a_fifo_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
    !fifo_cond |=> !fifo_q)
    else $error("fifo flag not removed");
  a_low_qualify: assert property (@(posedge core_clk) disable iff (!reset_n)
    low_hit |-> mod_data_valid && sel_data < low_q)
    else $error("low hit without low sample");
  a_high_qualify: assert property (@(posedge core_clk) disable iff (!reset_n)
    high_hit |-> mod_data_valid && sel_data > high_q)
    else $error("high hit without high sample");
  a_low_persist: assert property (@(posedge core_clk) disable iff (!reset_n)
    low_hit |-> low_run_q >= {1'b0, light_persistence_count})
    else $error("low hit before persistence");
  a_low_fire: assert property (@(posedge core_clk) disable iff (!reset_n)
    mod_data_valid && sel_data < low_q && low_run_q >= {1'b0, light_persistence_count} |-> low_hit)
    else $error("low hit missing after persistence");
  a_high_persist: assert property (@(posedge core_clk) disable iff (!reset_n)
    high_hit |-> high_run_q >= {1'b0, light_persistence_count})
    else $error("high hit before persistence");
  a_high_fire: assert property (@(posedge core_clk) disable iff (!reset_n)
    mod_data_valid && sel_data > high_q && high_run_q >= {1'b0, light_persistence_count} |-> high_hit)
    else $error("high hit missing after persistence");
  a_sel_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    int'(limit_source_select) < NMOD |-> sel_data == mod_data[int'(limit_source_select)*24 +: 24])
    else $error("wrong modulator compared");
  a_irq_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    !sat_q && !light_q && !fifo_q && !sys_q |-> irq_n)
    else $error("interrupt pin stuck");
  a_irq_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    sat_q || light_q || fifo_q || sys_q |-> !irq_n)
    else $error("interrupt pin released early");
  a_part_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd && reg_addr == `LTS_ADDR_PART |=> reg_rdata == PART_CODE)
    else $error("part code wrong");
  a_pkg_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd && reg_addr == `LTS_ADDR_PKG_FAB |=> reg_rdata == {4'h0, PKG_FAB_CODE})
    else $error("package code wrong");
  a_unmapped_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd && reg_addr < `LTS_ADDR_LOW_B0 |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_high_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_wr && reg_addr == `LTS_ADDR_HIGH_B0 |=> high_q[7:0] == $past(reg_wdata))
    else $error("high limit write lost");
  a_limit_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_status |=> low_q == $past(low_q) && high_q == $past(high_q))
    else $error("limit changed by status write");
  a_sat_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    sat_q && !sat_clr |=> sat_q)
    else $error("saturation flag lost");
  a_light_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    light_q && !light_clr |=> light_q)
    else $error("light flag lost");
endmodule : lts_irq_status

// [verif/lts_host_model.sv]
module lts_host_model
(
  // Clock
  input wire logic core_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Interrupt pin
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // A slow host leaves idle cycles between accesses
  task automatic idle();
    repeat ($urandom_range(0, 2)) @(posedge core_clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    idle();
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Stale data would hide a missing strobe qualification
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    idle();
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : lts_host_model

// [verif/testbench.sv]
module testbench
  import lts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = 8'h93;
  logic core_clk, reset_n, reg_wr, reg_rd, irq_n, mod_data_valid;
  logic light_irq_enable, system_irq_enable, saturation_event, system_event;
  logic low_crossing_flag, high_crossing_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_fill_threshold, fifo_fill_level, r, b, t;
  logic [3:0] light_persistence_count;
  logic [1:0] limit_source_select;
  logic [71:0] mod_data;
  lts_limit_type lim, lo, hi, dv, ot;
  int n_fail, tests_run, p;

  // Identification values are arbitrary
  lts_irq_status #(.PKG_FAB_CODE(4'h5), .DIE_VERSION_CODE(8'h2b), .PART_CODE(8'hc4)) DUT (
    .core_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .light_irq_enable, .system_irq_enable, .light_persistence_count, .limit_source_select,
    .fifo_fill_threshold, .mod_data, .mod_data_valid, .saturation_event, .fifo_fill_level,
    .system_event, .low_crossing_flag, .high_crossing_flag, .irq_n);
  lts_host_model H (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .irq_n);

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    H.rd(a, r);
    chk($sformatf("reg_%h", a), e, r);
  endtask : rchk

  function automatic logic [7:0] stat(input logic s, input logic l, input logic f, input logic y);
    return {s, 3'b000, l, f, 1'b0, y};
  endfunction : stat

  task automatic samp(input lts_limit_type v, input lts_limit_type o);
    logic [71:0] m;
    m = {3{o}};
    m[limit_source_select*24 +: 24] = v;
    @(posedge core_clk);
    mod_data <= m;
    mod_data_valid <= 1'b1;
    @(posedge core_clk);
    mod_data_valid <= 1'b0;
  endtask : samp

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    {reset_n, light_irq_enable, system_irq_enable, saturation_event, system_event} = '0;
    {mod_data_valid, light_persistence_count, limit_source_select, mod_data} = '0;
    fifo_fill_threshold = 8'hff;
    fifo_fill_level = 8'h00;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(89));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++)
      rchk(8'(8'h8a + i), (i == 6) ? 8'h05 : (i == 7) ? 8'h2b : (i == 8) ? 8'hc4 : 8'h00);
    rchk(8'h80, 8'h00);
    H.wr(8'h92, 8'hff);
    rchk(8'h92, 8'hc4);
    H.wr(ST, 8'h72);
    rchk(ST, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      b = 8'($urandom);
      H.wr(8'(8'h8a + i), b);
      rchk(8'(8'h8a + i), b);
    end
    $display("test registers done");
    for (int k = 0; k < 3; k++)
    begin
      p = $urandom_range(0, 3);
      lim = 24'($urandom_range(1, 24'hfffffe));
      lo = (k == 1) ? 24'h000000 : lim;
      hi = (k == 1) ? lim : 24'hffffff;
      dv = (k == 1) ? lim + 24'h1 : lim - 24'h1;
      ot = (k == 1) ? 24'h000000 : 24'hffffff;
      @(posedge core_clk);
      light_persistence_count <= 4'(p);
      limit_source_select <= 2'($urandom_range(0, 2));
      light_irq_enable <= (k != 2);
      for (int i = 0; i < 3; i++)
      begin
        H.wr(8'(8'h8a + i), lo[i*8 +: 8]);
        H.wr(8'(8'h8d + i), hi[i*8 +: 8]);
      end
      // An equal sample must break the run
      repeat (p) samp(dv, ot);
      samp(lim, ot);
      repeat (p) samp(dv, ot);
      repeat (3) @(posedge core_clk);
      rchk(ST, 8'h00);
      samp(dv, ot);
      repeat (3) @(posedge core_clk);
      rchk(ST, stat(1'b0, k != 2, 1'b0, 1'b0));
      if (k < 2)
        chk("cross_flag", 8'h01, {7'h0, (k == 1) ? high_crossing_flag : low_crossing_flag});
      chk("irq_n", {7'h0, k == 2}, {7'h0, irq_n});
      H.wr(ST, 8'h08);
      rchk(ST, 8'h00);
      chk("irq_n", 8'h01, {7'h0, irq_n});
    end
    $display("test limits done");
    @(posedge core_clk);
    saturation_event <= 1'b1;
    system_event <= 1'b1;
    @(posedge core_clk);
    saturation_event <= 1'b0;
    system_event <= 1'b0;
    system_irq_enable <= 1'b1;
    rchk(ST, stat(1'b1, 1'b0, 1'b0, 1'b0));
    @(posedge core_clk);
    system_event <= 1'b1;
    @(posedge core_clk);
    system_event <= 1'b0;
    rchk(ST, stat(1'b1, 1'b0, 1'b0, 1'b1));
    H.wr(ST, 8'h80);
    rchk(ST, stat(1'b0, 1'b0, 1'b0, 1'b1));
    chk("irq_n", 8'h00, {7'h0, irq_n});
    H.wr(ST, 8'h01);
    rchk(ST, 8'h00);
    $display("test events done");
    t = 8'($urandom_range(1, 255));
    @(posedge core_clk);
    fifo_fill_threshold <= t;
    fifo_fill_level <= t - 8'h01;
    rchk(ST, 8'h00);
    @(posedge core_clk);
    fifo_fill_level <= t;
    rchk(ST, stat(1'b0, 1'b0, 1'b1, 1'b0));
    H.wr(ST, 8'h04);
    rchk(ST, stat(1'b0, 1'b0, 1'b1, 1'b0));
    @(posedge core_clk);
    fifo_fill_level <= t - 8'h01;
    rchk(ST, 8'h00);
    $display("test fifo done");
    conclude();
  end
endmodule : testbench
